// file: src/abc_pkg.sv
// Package for the auxiliary bus control block: register map, field layout,
// reset values, cycle counts and the carrier structs.
// Assumes a single 100 MHz core clock that also stands for the oscillator.
`default_nettype none
package abc_pkg;

    // Register map
    localparam logic [7:0]  ABC_AUX_OFFSET      = 8'h8E;
    localparam logic [7:0]  ABC_AUX_RESET       = 8'h00;
    localparam logic [7:0]  ABC_AUX_WR_MASK     = 8'hAF;

    // Field positions inside the auxiliary register
    localparam int          ABC_BIT_SUPPRESS    = 0;
    localparam int          ABC_BIT_EXT_RAM     = 1;
    localparam int          ABC_BIT_SIZE_LO     = 2;
    localparam int          ABC_BIT_SIZE_HI     = 3;
    localparam int          ABC_BIT_STRETCH     = 5;
    localparam int          ABC_BIT_PU_DISABLE  = 7;

    // Expanded-RAM configuration bit inside the security configuration byte
    localparam int          ABC_SCB_XRAM_BIT    = 3;

    // Strobe widths in clock periods
    localparam logic [4:0]  ABC_STROBE_NORM_CYC = 5'h06;
    localparam logic [4:0]  ABC_STROBE_LONG_CYC = 5'h1E;

    // Address latch strobe period: 1/6 of the oscillator, 1/3 in double speed
    localparam logic [2:0]  ABC_ALE_DIV_STD     = 3'h6;
    localparam logic [2:0]  ABC_ALE_DIV_X2      = 3'h3;

    // Usable expanded-RAM sizes in bytes
    localparam logic [10:0] ABC_XRAM_256        = 11'h100;
    localparam logic [10:0] ABC_XRAM_512        = 11'h200;
    localparam logic [10:0] ABC_XRAM_768        = 11'h300;
    localparam logic [10:0] ABC_XRAM_1024       = 11'h400;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } abc_reg_req_s;

    // External-data move request from the core
    typedef struct packed {
        logic        start;
        logic        write;
        logic [15:0] addr;
    } abc_move_req_s;

    // External multiplexed bus controls
    typedef struct packed {
        logic [15:0] addr;
        logic        rd_n;
        logic        wr_n;
    } abc_ext_bus_s;

endpackage : abc_pkg
`default_nettype wire

// file: src/abc_strobe_timer.sv
// Strobe timer: holds busy for a loaded number of clock periods.
// Assumes start is a one-cycle pulse and is not raised while busy.
`default_nettype none
module abc_strobe_timer
    import abc_pkg::*;
#(
    parameter int CW = 5
)
(
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          rst,
    // Control
    input  wire logic          start,
    input  wire logic [CW-1:0] length,
    // Status
    output logic               busy,
    output logic               last
);

    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;

    always_comb
    begin
        count_nxt = count_r;
        if (start)
            count_nxt = length;
        else if (count_r != '0)
            count_nxt = count_r - 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            count_r <= '0;
        else
            count_r <= count_nxt;
    end

    assign busy = (count_r != '0);
    assign last = (count_r == {{(CW-1){1'b0}}, 1'b1});

endmodule : abc_strobe_timer
`default_nettype wire

// file: src/abc_aux_bus_ctrl.sv
// Auxiliary bus control: one control register that shapes the address latch
// strobe, the data-move strobe width, expanded-RAM size and routing, and the
// port weak pull-ups. Assumes a plain register port and synchronous inputs.
//
// The plain strobed port was chosen for this implementation.
`default_nettype none

module abc_aux_bus_ctrl
    import abc_pkg::*;
#(
    parameter int PORT_W = 8
)
(
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                rst,
    // Register port
    input  wire abc_reg_req_s        reg_req,
    output logic [7:0]               reg_rdata,
    // Configuration inputs
    input  wire logic [7:0]          security_config_byte,
    input  wire logic                double_speed_mode,
    // Core activity that needs the latch strobe
    input  wire logic                code_table_read,
    input  wire logic                ext_fetch,
    // Data-move request and answer
    input  wire abc_move_req_s       move_req,
    output logic                     move_busy,
    output logic                     move_done,
    // Internal expanded RAM access
    output logic                     xram_en,
    output logic                     xram_write,
    output logic [9:0]               xram_addr,
    // External bus
    output abc_ext_bus_s             ext_bus,
    output logic                     ale_out,
    output logic                     ale_oe,
    output logic                     ale_weak_pullup,
    // Port pull-ups
    input  wire logic [PORT_W-1:0]   port_latch,
    output logic [PORT_W-1:0]        port_pullup_en
);

    typedef enum logic [1:0] {
        MV_IDLE   = 2'b00,
        MV_ALE    = 2'b01,
        MV_STROBE = 2'b10,
        MV_DONE   = 2'b11
    } abc_move_e;

    // Usable expanded-RAM size for a size field value
    function automatic logic [10:0] abc_xram_limit(input logic [1:0] size);
        logic [10:0] lim;
        lim = ABC_XRAM_256;
        unique case (size)
            2'b00: lim = ABC_XRAM_256;
            2'b01: lim = ABC_XRAM_512;
            2'b10: lim = ABC_XRAM_768;
            2'b11: lim = ABC_XRAM_1024;
        endcase
        return lim;
    endfunction : abc_xram_limit

    // Register state
    logic [7:0]      aux_r;
    logic [7:0]      aux_nxt;
    logic [7:0]      rdata_r;
    logic [7:0]      rdata_nxt;
    logic            load_pend_r;
    logic            load_pend_nxt;

    // Latch strobe generator state
    logic [2:0]      ale_cnt_r;
    logic [2:0]      ale_cnt_nxt;
    logic            ale_r;
    logic            ale_nxt;
    logic            ale_oe_r;
    logic            ale_oe_nxt;

    // Data-move sequencer state
    abc_move_e       mv_r;
    abc_move_e       mv_nxt;
    abc_ext_bus_s    bus_r;
    abc_ext_bus_s    bus_nxt;
    logic            xen_r;
    logic            xen_nxt;
    logic            xwr_r;
    logic            xwr_nxt;
    logic [9:0]      xaddr_r;
    logic [9:0]      xaddr_nxt;
    logic            done_r;
    logic            done_nxt;
    logic [PORT_W-1:0] pu_r;
    logic [PORT_W-1:0] pu_nxt;

    // Decoded fields
    logic            suppress;
    logic            stretch;
    logic            ext_select;
    logic            pu_disable;
    logic [1:0]      xram_size;
    logic            to_internal;
    logic            tmr_start;
    logic            tmr_busy;
    logic            tmr_last;
    logic [4:0]      strobe_len;
    logic [2:0]      ale_div;

    assign suppress   = aux_r[ABC_BIT_SUPPRESS];
    assign stretch    = aux_r[ABC_BIT_STRETCH];
    assign ext_select = aux_r[ABC_BIT_EXT_RAM];
    assign pu_disable = aux_r[ABC_BIT_PU_DISABLE];
    assign xram_size  = {aux_r[ABC_BIT_SIZE_HI], aux_r[ABC_BIT_SIZE_LO]};

    assign strobe_len = stretch ? ABC_STROBE_LONG_CYC : ABC_STROBE_NORM_CYC;
    assign ale_div    = double_speed_mode ? ABC_ALE_DIV_X2 : ABC_ALE_DIV_STD;

    // Moves above the selected size fall through to the external bus
    assign to_internal = !ext_select
                         && ({1'b0, move_req.addr} < {6'h00, abc_xram_limit(xram_size)});

    // Register file
    always_comb
    begin
        aux_nxt       = aux_r;
        rdata_nxt     = 8'h00;
        load_pend_nxt = 1'b0;
        if (load_pend_r)
            aux_nxt[ABC_BIT_EXT_RAM] = ~security_config_byte[ABC_SCB_XRAM_BIT];
        if (reg_req.wr && reg_req.addr == ABC_AUX_OFFSET)
            aux_nxt = reg_req.wdata & ABC_AUX_WR_MASK;
        if (reg_req.rd && reg_req.addr == ABC_AUX_OFFSET)
            rdata_nxt = aux_r;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            aux_r       <= ABC_AUX_RESET;
            rdata_r     <= 8'h00;
            load_pend_r <= 1'b1;
        end
        else
        begin
            aux_r       <= aux_nxt;
            rdata_r     <= rdata_nxt;
            load_pend_r <= load_pend_nxt;
        end
    end

    // Data-move sequencer
    always_comb
    begin
        mv_nxt    = mv_r;
        bus_nxt   = bus_r;
        xen_nxt   = 1'b0;
        xwr_nxt   = 1'b0;
        xaddr_nxt = xaddr_r;
        done_nxt  = 1'b0;
        tmr_start = 1'b0;
        unique case (mv_r)
            MV_IDLE:
            begin
                if (move_req.start)
                begin
                    if (to_internal)
                    begin
                        xen_nxt   = 1'b1;
                        xwr_nxt   = move_req.write;
                        xaddr_nxt = move_req.addr[9:0];
                        mv_nxt    = MV_DONE;
                    end
                    else
                    begin
                        bus_nxt.addr = move_req.addr;
                        bus_nxt.rd_n = 1'b1;
                        bus_nxt.wr_n = 1'b1;
                        mv_nxt       = MV_ALE;
                    end
                end
            end
            MV_ALE:
            begin
                tmr_start    = 1'b1;
                bus_nxt.rd_n = xwr_r;
                bus_nxt.wr_n = !xwr_r;
                mv_nxt       = MV_STROBE;
            end
            MV_STROBE:
            begin
                if (tmr_last)
                begin
                    bus_nxt.rd_n = 1'b1;
                    bus_nxt.wr_n = 1'b1;
                    mv_nxt       = MV_DONE;
                end
            end
            MV_DONE:
            begin
                done_nxt = 1'b1;
                mv_nxt   = MV_IDLE;
            end
        endcase
        // Direction of an external move is kept in the write flag
        if (mv_r == MV_IDLE && move_req.start && !to_internal)
            xwr_nxt = move_req.write;
        else if (mv_r == MV_ALE || mv_r == MV_STROBE)
            xwr_nxt = xwr_r;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            mv_r    <= MV_IDLE;
            bus_r   <= '{addr: 16'h0000, rd_n: 1'b1, wr_n: 1'b1};
            xen_r   <= 1'b0;
            xwr_r   <= 1'b0;
            xaddr_r <= 10'h000;
            done_r  <= 1'b0;
        end
        else
        begin
            mv_r    <= mv_nxt;
            bus_r   <= bus_nxt;
            xen_r   <= xen_nxt;
            xwr_r   <= xwr_nxt;
            xaddr_r <= xaddr_nxt;
            done_r  <= done_nxt;
        end
    end

    abc_strobe_timer #(
        .CW (5)
    ) u_strobe_timer (
        .clock  (clock),
        .rst    (rst),
        .start  (tmr_start),
        .length (strobe_len),
        .busy   (tmr_busy),
        .last   (tmr_last)
    );

    // Latch strobe: free-running divider, gated by the suppress bit
    always_comb
    begin
        ale_cnt_nxt = ale_cnt_r + 3'h1;
        if (ale_cnt_r >= ale_div - 3'h1)
            ale_cnt_nxt = 3'h0;
        if (!suppress)
        begin
            ale_nxt    = (ale_cnt_r == 3'h0);
            ale_oe_nxt = 1'b1;
        end
        else if (code_table_read || ext_fetch || mv_r == MV_ALE)
        begin
            ale_nxt    = code_table_read || ext_fetch ? (ale_cnt_r == 3'h0)
                                                      : 1'b1;
            ale_oe_nxt = 1'b1;
        end
        else
        begin
            ale_nxt    = 1'b0;
            ale_oe_nxt = 1'b0;
        end
        if (!suppress && mv_r == MV_ALE)
            ale_nxt = 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ale_cnt_r <= 3'h0;
            ale_r     <= 1'b0;
            ale_oe_r  <= 1'b0;
        end
        else
        begin
            ale_cnt_r <= ale_cnt_nxt;
            ale_r     <= ale_nxt;
            ale_oe_r  <= ale_oe_nxt;
        end
    end

    // Port weak pull-ups
    always_comb
    begin
        pu_nxt = pu_disable ? '0 : port_latch;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            pu_r <= '0;
        else
            pu_r <= pu_nxt;
    end

    // Outputs
    assign reg_rdata       = rdata_r;
    assign move_busy       = (mv_r != MV_IDLE) || tmr_busy;
    assign move_done       = done_r;
    assign xram_en         = xen_r;
    assign xram_write      = xwr_r & xen_r;
    assign xram_addr       = xaddr_r;
    assign ext_bus         = bus_r;
    assign ale_out         = ale_r & ale_oe_r;
    assign ale_oe          = ale_oe_r;
    assign ale_weak_pullup = !ale_oe_r;
    assign port_pullup_en  = pu_r;

endmodule : abc_aux_bus_ctrl
`default_nettype wire

// file: tb/abc_aux_bus_ctrl_properties.sv
// Checker for the auxiliary bus control block, bound to its top module.
// Assumes size and stretch fields stay put while a move runs.
`default_nettype none
module abc_aux_bus_ctrl_properties
    import abc_pkg::*;
#(
    parameter int PORT_W = 8
)
(
    // Clock and reset
    input wire logic              clock,
    input wire logic              rst,
    // Requests
    input wire abc_reg_req_s      reg_req,
    input wire logic              double_speed_mode,
    input wire logic              code_table_read,
    input wire logic              ext_fetch,
    input wire abc_move_req_s     move_req,
    input wire logic [PORT_W-1:0] port_latch,
    // Answers
    input wire logic              move_busy,
    input wire logic              move_done,
    input wire logic              xram_en,
    input wire abc_ext_bus_s      ext_bus,
    input wire logic              ale_out,
    input wire logic              ale_oe,
    input wire logic              ale_weak_pullup,
    input wire logic [PORT_W-1:0] port_pullup_en
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       sup_r;
    logic       mo_r;
    logic       pud_r;
    logic [1:0] sz_r;
    logic [5:0] low_r;
    logic       quiet;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Mirror of the register fields and the strobe low-time counter
    always_ff @(posedge clock)
    begin
        if (rst)
            {pud_r, mo_r, sz_r, sup_r} <= '0;
        else if (reg_req.wr && reg_req.addr == ABC_AUX_OFFSET)
            {pud_r, mo_r, sz_r, sup_r} <= {reg_req.wdata[7], reg_req.wdata[5],
                                           reg_req.wdata[3:2], reg_req.wdata[0]};
        low_r <= (!ext_bus.rd_n || !ext_bus.wr_n) ? low_r + 6'h01 : 6'h00;
    end
    assign quiet = !sup_r && !move_busy && !move_req.start;

    AST_WEAK_PULL: assert property (ale_weak_pullup == !ale_oe)
        else $error("Weak pull-up does not mirror strobe drive");
    AST_SUPPRESS_IDLE: assert property ((sup_r && !code_table_read && !ext_fetch
        && !move_busy && !move_req.start)[*2] |-> !ale_oe)
        else $error("Strobe driven while suppressed and idle");
    AST_SUPPRESS_ACTIVE: assert property (sup_r && $past(sup_r)
        && $past(code_table_read || ext_fetch) |-> ale_oe)
        else $error("Strobe not driven for table read or fetch");
    AST_ALE_PERIOD6: assert property (ale_out && quiet && !double_speed_mode
        && !$past(double_speed_mode) ##1 (quiet && !double_speed_mode && !ale_out)[*5]
        |=> ale_out)
        else $error("Strobe period not six clocks");
    AST_ALE_PERIOD3: assert property (ale_out && quiet && double_speed_mode
        && $past(double_speed_mode) ##1 (quiet && double_speed_mode && !ale_out)[*2]
        |=> ale_out)
        else $error("Strobe period not three clocks");
    AST_STROBE_WIDTH: assert property ($rose(ext_bus.rd_n) || $rose(ext_bus.wr_n)
        |-> low_r == (mo_r ? 6'h1E : 6'h06))
        else $error("Read or write strobe width wrong");
    AST_MOVE_ROUTE: assert property (move_req.start && !move_busy
        |=> (xram_en ##1 move_done) or ##1 (!ext_bus.rd_n || !ext_bus.wr_n))
        else $error("Move neither internal nor external");
    AST_XRAM_SIZE: assert property (xram_en
        |-> 32'($past(move_req.addr)) < ((32'(sz_r) + 1) << 8))
        else $error("Internal access beyond selected size");
    AST_PULLUP: assert property (!$past(rst)
        |-> port_pullup_en == ($past(port_latch) & ~{PORT_W{$past(pud_r)}}))
        else $error("Port pull-up enables wrong");

    COV_INTERNAL: cover property (xram_en);
    COV_EXTERNAL: cover property ($rose(ext_bus.rd_n));
    COV_SUPPRESSED: cover property (sup_r && !ale_oe);
endmodule : abc_aux_bus_ctrl_properties

bind abc_aux_bus_ctrl abc_aux_bus_ctrl_properties #(.PORT_W(PORT_W)) u_props (
    .clock, .rst, .reg_req, .double_speed_mode, .code_table_read, .ext_fetch,
    .move_req, .port_latch, .move_busy, .move_done, .xram_en, .ext_bus, .ale_out,
    .ale_oe, .ale_weak_pullup, .port_pullup_en);
`default_nettype wire

// file: tb/abc_ext_mem.sv
// Far-side memory model: records the width and address of each strobe.
// Assumes the bus controls are registered on the core clock.
`default_nettype none
module abc_ext_mem
    import abc_pkg::*;
(
    // Clock and reset
    input wire logic          clock,
    input wire logic          rst,
    // Bus and observations
    input wire abc_ext_bus_s  ext_bus,
    output logic [5:0]        last_w,
    output logic [15:0]       last_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] cnt;

    always_ff @(posedge clock)
    begin
        if (rst)
            {cnt, last_w, last_addr} <= '0;
        else if (!ext_bus.rd_n || !ext_bus.wr_n)
            {cnt, last_addr} <= {cnt + 6'h01, ext_bus.addr};
        else
            {cnt, last_w} <= {6'h00, (cnt != 6'h00) ? cnt : last_w};
    end
endmodule : abc_ext_mem
`default_nettype wire

// file: tb/test_abc_aux_bus_ctrl.sv
// Testbench: register, move and strobe sequences with expected values.
// Assumes the checker is bound in and the memory model watches the bus.
`default_nettype none
module test_abc_aux_bus_ctrl
    import abc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, a, e); end end
    logic          clock, rst, double_speed_mode, code_table_read, ext_fetch, seen;
    logic [7:0]    security_config_byte, port_latch, reg_rdata, port_pullup_en;
    logic          move_busy, move_done, xram_en, xram_write, ale_out, ale_oe;
    logic          ale_weak_pullup;
    logic [9:0]    xram_addr;
    logic [5:0]    last_w;
    logic [15:0]   last_addr;
    abc_reg_req_s  reg_req;
    abc_move_req_s move_req;
    abc_ext_bus_s  ext_bus;
    int            num_errors, n_tests, s;

    abc_aux_bus_ctrl DUT (.clock, .rst, .reg_req, .reg_rdata, .security_config_byte,
        .double_speed_mode, .code_table_read, .ext_fetch, .move_req, .move_busy,
        .move_done, .xram_en, .xram_write, .xram_addr, .ext_bus, .ale_out, .ale_oe,
        .ale_weak_pullup, .port_latch, .port_pullup_en);
    abc_ext_mem MEM (.clock, .rst, .ext_bus, .last_w, .last_addr);

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock) reg_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock) reg_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock) reg_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock) reg_req.rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask : rd

    task automatic mv(input logic w, input logic [15:0] a, input logic in, input int n);
        int   c;
        logic xe;
        xe = 1'b0;
        seen = 1'b0;
        @(posedge clock) move_req <= '{1'b1, w, a};
        @(posedge clock) move_req.start <= 1'b0;
        for (c = 0; c < 60; c++)
        begin
            #1;
            if (c == 0)
                `CHK(move_busy, 1'b1)
            if (ext_bus.rd_n === 1'b0 || ext_bus.wr_n === 1'b0)
                `CHK({ext_bus.rd_n, ext_bus.wr_n}, {w, !w})
            if (xram_en === 1'b1)
            begin
                xe = 1'b1;
                `CHK({xram_write, xram_addr}, {w, a[9:0]})
            end
            if (ale_out === 1'b1)
                seen = 1'b1;
            if (move_done === 1'b1)
                break;
            @(posedge clock);
        end
        `CHK({move_done, move_busy, xe}, {1'b1, 1'b0, in})
        if (!in)
            `CHK({last_w, last_addr}, {6'(n), a})
    endtask : mv

    task automatic per(input logic ds, input int e);
        int c;
        @(posedge clock) double_speed_mode <= ds;
        repeat (20) @(posedge clock);
        #1;
        for (c = 0; c < 20 && ale_out !== 1'b1; c++)
            @(posedge clock) #1;
        for (c = 1; c < 20; c++)
        begin
            @(posedge clock) #1;
            if (ale_out === 1'b1)
                break;
        end
        `CHK(c, e)
    endtask : per

    task automatic give_verdict;
        $display("Comparisons %0d, errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        num_errors++;
        give_verdict;
    end

    initial
    begin
        {rst, double_speed_mode, code_table_read, ext_fetch} = 4'h8;
        {reg_req, move_req} = '0;
        security_config_byte = 8'hF7;
        port_latch = 8'h5A;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        rd(8'h8E, 8'h02);
        rd(8'h8F, 8'h00);
        mv(1'b0, 16'h0010, 1'b0, 6);
        wr(8'h8E, 8'hAF);
        rd(8'h8E, 8'hAF);
        repeat (3) @(posedge clock);
        #1 `CHK(port_pullup_en, 8'h00)
        wr(8'h8E, 8'h00);
        repeat (3) @(posedge clock);
        #1 `CHK(port_pullup_en, 8'h5A)
        for (s = 0; s < 4; s++)
        begin
            wr(8'h8E, {2'b00, s == 3, 1'b0, s[1:0], 2'b00});
            mv(s[0], 16'(s * 256 + 255), 1'b1, 6);
            mv(!s[0], 16'((s + 1) * 256), 1'b0, (s == 3) ? 30 : 6);
        end
        per(1'b0, 6);
        per(1'b1, 3);
        @(posedge clock) double_speed_mode <= 1'b0;
        wr(8'h8E, 8'h01);
        repeat (4) @(posedge clock);
        #1 `CHK({ale_oe, ale_weak_pullup}, 2'b01)
        @(posedge clock) code_table_read <= 1'b1;
        repeat (4) @(posedge clock);
        #1 `CHK(ale_oe, 1'b1)
        @(posedge clock) {code_table_read, ext_fetch} <= 2'b01;
        repeat (4) @(posedge clock);
        #1 `CHK(ale_oe, 1'b1)
        @(posedge clock) ext_fetch <= 1'b0;
        wr(8'h8E, 8'h03);
        mv(1'b1, 16'h0020, 1'b0, 6);
        `CHK(seen, 1'b1)
        // Second reset with an unprogrammed security byte: internal RAM selected
        @(posedge clock) {rst, security_config_byte} <= {1'b1, 8'hFF};
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        #1 `CHK({ale_oe, ale_weak_pullup, move_done, ext_bus.rd_n}, 4'b0101)
        rd(8'h8E, 8'h00);
        `CHK(ale_oe, 1'b1)
        give_verdict;
    end
endmodule : test_abc_aux_bus_ctrl
`default_nettype wire
